// >>> verilog/mux_addr_pkg.sv
// shared constants, command codes and pin mapping of the multiplexed address link
package mux_addr_pkg;
  // ==================================================
  // widths and clock
  localparam int unsigned addr_w    = 21;
  localparam int unsigned bank_w    = 4;
  localparam int unsigned banks     = 16;
  localparam int unsigned half_pins = 11;
  localparam int unsigned clk_mhz   = 20;

  // ==================================================
  // timing, least times rounded up to whole cycles
  localparam int unsigned row_cycle_time_ns = 100;
  localparam int unsigned mode_set_wait_ns  = 600;
  localparam int unsigned mb_min_delay_ns   = 100;
  localparam int unsigned mb_window_ns      = 1000;
  localparam int unsigned mb_window_max     = 4;
  localparam int unsigned row_cycle_cyc     = (row_cycle_time_ns * clk_mhz + 999) / 1000;
  localparam int unsigned mode_set_wait_cyc = (mode_set_wait_ns * clk_mhz + 999) / 1000;
  localparam int unsigned mb_min_delay_cyc  = (mb_min_delay_ns * clk_mhz + 999) / 1000;
  localparam int unsigned mb_window_cyc     = (mb_window_ns * clk_mhz + 999) / 1000;

  // ==================================================
  // mode register fields
  localparam int unsigned mux_bit      = 9;
  localparam int unsigned lat_lsb      = 0;
  localparam int unsigned burst_lsb    = 3;
  localparam int unsigned term_lsb     = 0;
  localparam logic [20:0] zero_used    = 21'h00020f;
  localparam logic [20:0] one_used     = 21'h00001b;
  localparam logic [20:0] two_used     = 21'h0000ff;
  localparam logic [1:0]  sel_zero     = 2'h0;
  localparam logic [1:0]  sel_one      = 2'h1;
  localparam logic [1:0]  sel_two      = 2'h2;
  localparam logic [1:0]  burst_two    = 2'h0;
  localparam logic [1:0]  burst_four   = 2'h1;
  localparam logic [1:0]  burst_of_eight = 2'h2;

  // ==================================================
  // controller register map
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] addr_off   = 8'h04;
  localparam logic [7:0] mask_off   = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;
  localparam logic [7:0] zero_off   = 8'h10;
  localparam logic [7:0] one_off    = 8'h14;
  localparam logic [7:0] two_off    = 8'h18;
  localparam int unsigned go_bit    = 0;
  localparam int unsigned init_bit  = 1;
  localparam int unsigned cmd_lsb   = 4;
  localparam int unsigned bank_lsb  = 8;

  typedef enum logic [2:0] {
    c_read          = 3'h0,
    c_write         = 3'h1,
    c_mode_write    = 3'h2,
    c_refresh_bank  = 3'h3,
    c_refresh_multi = 3'h4
  } cmd_t;

  // ==================================================
  // pins used by both halves, and the address bit each carries in the second half
  localparam logic [4:0] no_src = 5'h1f;
  localparam logic [4:0] pin_idx [half_pins] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09,
                                                5'h0a, 5'h0d, 5'h0e, 5'h11, 5'h12};
  localparam logic [4:0] sh_src  [half_pins] = '{no_src, 5'h01, 5'h02, 5'h14, 5'h06, 5'h07,
                                                5'h13, 5'h0b, 5'h0c, 5'h10, 5'h0f};

  function automatic logic sh_used(input logic [4:0] src, input logic w36, input logic [1:0] bl);
    if (src == 5'h13) return (bl == burst_two) | (~w36 & (bl == burst_four));
    if (src == 5'h14) return ~w36 & (bl == burst_two);
    return src != no_src;
  endfunction

  function automatic logic [20:0] first_half(input logic [20:0] a);
    logic [20:0] p;
    p = '0;
    for (int i = 0; i < half_pins; i++) p[pin_idx[i]] = a[pin_idx[i]];
    return p;
  endfunction

  function automatic logic [20:0] second_half(input logic [20:0] a, input logic w36,
                                              input logic [1:0] bl);
    logic [20:0] p;
    p = '0;
    for (int i = 0; i < half_pins; i++)
      if (sh_used(sh_src[i], w36, bl)) p[pin_idx[i]] = a[sh_src[i]];
    return p;
  endfunction

  function automatic logic [20:0] merge_halves(input logic [20:0] f, input logic [20:0] s,
                                               input logic w36, input logic [1:0] bl);
    logic [20:0] a;
    a = '0;
    for (int i = 0; i < half_pins; i++) begin
      a[pin_idx[i]] = f[pin_idx[i]];
      if (sh_used(sh_src[i], w36, bl)) a[sh_src[i]] = s[pin_idx[i]];
    end
    return a;
  endfunction

  // eight bank-mask lanes per half ride on the first eight shared pins
  function automatic logic [20:0] mask_to_pins(input logic [7:0] m);
    logic [20:0] p;
    p = '0;
    for (int i = 0; i < 8; i++) p[pin_idx[i]] = m[i];
    return p;
  endfunction

  function automatic logic [7:0] pins_to_mask(input logic [20:0] p);
    logic [7:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) m[i] = p[pin_idx[i]];
    return m;
  endfunction
endpackage

// >>> verilog/mux_link_if.sv
// command and address pins between controller and device
`timescale 1ns/1ps
interface mux_link_if;
  logic        cs_n;
  logic        we_n;
  logic        ref_n;
  logic        mb_n;
  logic [20:0] addr;
  logic [3:0]  bank;

  modport ctrl (output cs_n, output we_n, output ref_n, output mb_n, output addr, output bank);
  modport dev  (input cs_n, input we_n, input ref_n, input mb_n, input addr, input bank);
endinterface

// >>> verilog/mux_addr_device.sv
// device end: decodes split-address commands and keeps the mode registers
`timescale 1ns/1ps
module mux_addr_device #(
  parameter bit wide36 = 1'b0
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       ce,
  mux_link_if.dev                         link,
  output logic                            rd_pulse_ff,
  output logic                            wr_pulse_ff,
  output logic                            ref_pulse_ff,
  output logic                            rc_start_ff,
  output logic                            rd_due_ff,
  output logic                            wr_due_ff,
  output logic                            mux_mode_ff,
  output logic                            odt_on_ff,
  output logic [1:0]                      odt_value_ff,
  output logic [mux_addr_pkg::addr_w-1:0] op_addr_ff,
  output logic [mux_addr_pkg::bank_w-1:0] op_bank_ff,
  output logic [mux_addr_pkg::banks-1:0]  ref_banks_ff
);
  import mux_addr_pkg::*;

  // ==================================================
  // pin decode
  logic        pend_ff;
  cmd_t        pcmd_ff;
  logic [20:0] fh_ff;
  logic [3:0]  pbank_ff;
  logic [1:0]  bl_ff;
  logic [1:0]  term_sel_ff;
  logic [3:0]  lat_ff;
  logic [15:0] rd_sr_ff;
  logic [15:0] wr_sr_ff;
  cmd_t        pin_cmd;
  cmd_t        ex_cmd;

  wire pin_mode = ~link.we_n & ~link.ref_n;
  assign pin_cmd = pin_mode ? c_mode_write : ~link.we_n ? c_write :
                   link.ref_n ? c_read : link.mb_n ? c_refresh_bank : c_refresh_multi;
  // the second-half edge is not a command, except after a bank refresh
  wire sh_cycle = pend_ff & (pcmd_ff != c_refresh_bank);
  wire take     = ~link.cs_n & ~sh_cycle;
  wire ex_v     = mux_mode_ff ? pend_ff : take;
  assign ex_cmd = mux_mode_ff ? pcmd_ff : pin_cmd;
  wire [20:0] ex_addr = mux_mode_ff ? merge_halves(fh_ff, link.addr, wide36, bl_ff) : link.addr;
  wire [3:0]  ex_bank = mux_mode_ff ? pbank_ff : link.bank;
  wire [15:0] ex_mask = mux_mode_ff ? {pins_to_mask(link.addr), pins_to_mask(fh_ff)}
                                    : link.addr[15:0];
  wire ex_rd    = ex_v & (ex_cmd == c_read);
  wire ex_wr    = ex_v & (ex_cmd == c_write);
  wire ex_bref  = ex_v & (ex_cmd == c_refresh_bank);
  wire ex_mref  = ex_v & (ex_cmd == c_refresh_multi);
  wire ex_mode  = ex_v & (ex_cmd == c_mode_write);

  // ==================================================
  // first half capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff  <= 1'b0;
      pcmd_ff  <= c_read;
      fh_ff    <= 21'h000000;
      pbank_ff <= 4'h0;
    end else if (ce) begin
      pend_ff <= take & mux_mode_ff;
      if (take) begin
        pcmd_ff  <= pin_cmd;
        fh_ff    <= link.addr;
        pbank_ff <= link.bank;
      end
    end
  end

  // ==================================================
  // operations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_pulse_ff  <= 1'b0;
      wr_pulse_ff  <= 1'b0;
      ref_pulse_ff <= 1'b0;
      rc_start_ff  <= 1'b0;
      op_addr_ff   <= 21'h000000;
      op_bank_ff   <= 4'h0;
      ref_banks_ff <= 16'h0000;
    end else if (ce) begin
      rd_pulse_ff  <= ex_rd;
      wr_pulse_ff  <= ex_wr;
      ref_pulse_ff <= ex_bref | ex_mref;
      rc_start_ff  <= take & (pin_cmd != c_mode_write);
      if (ex_rd | ex_wr) op_addr_ff <= ex_addr;
      if (ex_rd | ex_wr | ex_bref) op_bank_ff <= ex_bank;
      if (ex_bref) ref_banks_ff <= 16'h0001 << ex_bank;
      if (ex_mref) ref_banks_ff <= ex_mask;
    end
  end

  // ==================================================
  // mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mux_mode_ff  <= 1'b0;
      lat_ff       <= 4'h0;
      bl_ff        <= burst_two;
      term_sel_ff  <= 2'h0;
      odt_on_ff    <= 1'b0;
      odt_value_ff <= 2'h0;
    end else if (ce && ex_mode) begin
      unique case (ex_bank[1:0])
        sel_zero: begin
          mux_mode_ff <= ex_addr[mux_bit];
          lat_ff      <= ex_addr[lat_lsb+:4];
        end
        sel_one: begin
          bl_ff       <= ex_addr[burst_lsb+:2];
          term_sel_ff <= ex_addr[term_lsb+:2];
        end
        sel_two: begin
          odt_on_ff    <= term_sel_ff != 2'h0;
          odt_value_ff <= term_sel_ff;
        end
        default: ;
      endcase
    end
  end

  // ==================================================
  // data latency, counted from the execution edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_sr_ff  <= 16'h0000;
      wr_sr_ff  <= 16'h0000;
      rd_due_ff <= 1'b0;
      wr_due_ff <= 1'b0;
    end else if (ce) begin
      rd_sr_ff  <= {rd_sr_ff[14:0], ex_rd};
      wr_sr_ff  <= {wr_sr_ff[14:0], ex_wr};
      rd_due_ff <= rd_sr_ff[lat_ff];
      wr_due_ff <= wr_sr_ff[lat_ff];
    end
  end
endmodule

// >>> verilog/mux_addr_ctrl.sv
// controller end: apb registers, init sequence and split-address command issue
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Summary of operation
// - mode zero bit nine enables split addressing
// - wait mode-set interval after enabling
// - keep bit nine high on rewrites
// - write modes one, two in halves
// - follow fixed power-up order exactly
// - termination valid after mode two write
// - upper bank bits, reserved bits low
// - no burst of eight when wide
// - wide mapping across both halves
// - narrow mapping, extra high bits
// - latency counts from second half
// - row cycle counts from first half
// - refresh executes on following edge
// - bank refresh allows next clock command
// - multibank refresh needs two clocks
// - address lanes only for multibank refresh
// - bank pins only for bank refresh
// - respect multibank window and delay
module mux_addr_ctrl #(
  parameter bit wide36 = 1'b0
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_ff,
  output logic             pready_ff,
  output logic             pslverr_ff,
  mux_link_if.ctrl         link
);
  import mux_addr_pkg::*;

  typedef enum logic [1:0] {
    st_idle = 2'h0,
    st_fh   = 2'h1,
    st_sh   = 2'h2,
    st_wait = 2'h3
  } state_t;

  state_t      state_ff, nxt_state;
  logic        issue;
  logic        cs_n_ff, we_n_ff, ref_n_ff, mb_n_ff;
  logic [20:0] pin_addr_ff;
  logic [3:0]  pin_bank_ff;
  logic [20:0] uaddr_ff, zero_ff, one_ff, two_ff;
  logic [15:0] umask_ff;
  logic [3:0]  ubank_ff;
  cmd_t        ucmd_ff, cur_cmd_ff, go_cmd;
  logic [20:0] cur_addr_ff;
  logic [15:0] cur_mask_ff;
  logic        cur_mux_ff, mux_ff, pend_ff, init_ff, init_done_ff;
  logic [2:0]  step_ff;
  logic [1:0]  bl_ff;
  logic [7:0]  wait_ff, mbd_ff, saw_ff;
  logic [2:0]  saw_num_ff;
  logic [7:0]  rc_cnt_ff [banks];
  logic [15:0] busy;

  // ==================================================
  // apb decode
  wire setup    = psel & ~penable;
  wire take     = psel & penable & pready_ff;
  wire hit_ctrl = paddr == ctrl_off;
  wire hit_stat = paddr == status_off;
  wire mapped   = hit_ctrl | hit_stat | (paddr == addr_off) | (paddr == mask_off) |
                  (paddr == zero_off) | (paddr == one_off) | (paddr == two_off);
  wire cmd_bad  = pwdata[cmd_lsb+:3] > 3'h4;
  wire go_try   = pwrite & hit_ctrl & pwdata[go_bit];
  wire bad_acc  = ~mapped | (go_try & cmd_bad) | (pwrite & hit_stat);
  wire go_req   = take & go_try & ~cmd_bad & ~pend_ff & ~pslverr_ff;
  wire init_req = take & pwrite & hit_ctrl & pwdata[init_bit] & ~init_ff &
                  (state_ff == st_idle);
  wire [31:0] stat_word = {27'h0, init_ff, pend_ff, mux_ff, state_ff != st_idle, init_done_ff};
  wire [31:0] rd_word   = hit_ctrl ? {20'h0, ubank_ff, 1'b0, ucmd_ff, 4'h0} :
                          hit_stat ? stat_word :
                          paddr == addr_off ? {11'h0, uaddr_ff} :
                          paddr == mask_off ? {16'h0, umask_ff} :
                          paddr == zero_off ? {11'h0, zero_ff} :
                          paddr == one_off  ? {11'h0, one_ff} :
                          paddr == two_off  ? {11'h0, two_ff} : 32'h00000000;

  // answer in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff  <= rd_word;
        pslverr_ff <= bad_acc;
      end
    end
  end

  wire wr_ok = take & pwrite & ~pslverr_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uaddr_ff <= 21'h000000;
      umask_ff <= 16'h0000;
      zero_ff  <= 21'h000000;
      one_ff   <= 21'h000000;
      two_ff   <= 21'h000000;
      ucmd_ff  <= c_read;
      ubank_ff <= 4'h0;
    end else if (ce && wr_ok) begin
      if (paddr == addr_off) uaddr_ff <= pwdata[20:0];
      if (paddr == mask_off) umask_ff <= pwdata[15:0];
      if (paddr == zero_off) zero_ff <= pwdata[20:0];
      if (paddr == one_off) one_ff <= pwdata[20:0];
      if (paddr == two_off) two_ff <= pwdata[20:0];
      if (go_req) begin
        ucmd_ff  <= cmd_t'(pwdata[cmd_lsb+:3]);
        ubank_ff <= pwdata[bank_lsb+:4];
      end
    end
  end

  // ==================================================
  // what goes out next
  wire [1:0]  step_sel = step_ff == 3'h3 ? sel_two : step_ff == 3'h2 ? sel_one : sel_zero;
  wire [1:0]  go_sel   = init_ff ? step_sel : ubank_ff[1:0];
  wire [20:0] go_src   = ~init_ff ? uaddr_ff : step_sel == sel_zero ? zero_ff :
                         step_sel == sel_one ? one_ff : two_ff;
  assign go_cmd = init_ff ? c_mode_write : ucmd_ff;
  // wide parts fall back to four
  wire [1:0]  bl_req   = go_src[burst_lsb+:2];
  wire [1:0]  bl_fix   = (wide36 && bl_req == burst_of_eight) ? burst_four : bl_req;
  wire [20:0] go_mode  = go_sel == sel_zero ? (go_src | (21'h000001 << mux_bit)) & zero_used :
                         go_sel == sel_one ? {go_src[20:5], bl_fix, go_src[2:0]} & one_used :
                         go_src & two_used;
  wire [20:0] go_addr  = go_cmd == c_mode_write ? go_mode : go_src;
  wire is_multi = go_cmd == c_refresh_multi;
  // bank free once row cycle ran out
  wire bank_ok  = go_cmd == c_mode_write ? 1'b1 : is_multi ? ~|(busy & umask_ff) :
                  ~busy[ubank_ff];
  wire mb_ok    = ~is_multi | ((mbd_ff == 8'h00) &
                  ((saw_ff == 8'h00) | (saw_num_ff < 3'(mb_window_max))));
  // fixed init order before any user command
  wire want     = init_ff ? (step_ff < 3'h4) : (pend_ff & init_done_ff & bank_ok & mb_ok);
  // in split mode, second half for everything but bank refresh
  wire need_sh  = cur_mux_ff & (cur_cmd_ff != c_refresh_bank);
  wire need_wt  = cur_cmd_ff == c_mode_write;

  // ==================================================
  // issue sequencer
  always_comb begin
    nxt_state = state_ff;
    issue     = 1'b0;
    unique case (state_ff)
      st_idle: issue = want;
      st_fh: begin
        // back to back after bank refresh
        if (need_sh) nxt_state = st_sh;
        else if (need_wt) nxt_state = st_wait;
        else if (want) issue = 1'b1;
        else nxt_state = st_idle;
      end
      st_sh: nxt_state = need_wt ? st_wait : st_idle;
      st_wait: if (wait_ff == 8'h00) nxt_state = st_idle;
    endcase
    if (issue) nxt_state = st_fh;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= st_idle;
      wait_ff  <= 8'h00;
    end else if (ce) begin
      state_ff <= nxt_state;
      if (nxt_state == st_wait && state_ff != st_wait) wait_ff <= 8'(mode_set_wait_cyc - 1);
      else if (wait_ff != 8'h00) wait_ff <= wait_ff - 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff      <= 1'b0;
      init_ff      <= 1'b0;
      init_done_ff <= 1'b0;
      step_ff      <= 3'h0;
      mux_ff       <= 1'b0;
      bl_ff        <= burst_two;
    end else if (ce) begin
      if (issue && !init_ff) pend_ff <= 1'b0;
      if (go_req) pend_ff <= 1'b1;
      if (issue && init_ff) step_ff <= step_ff + 3'h1;
      // split format from the next command on
      if (issue && go_cmd == c_mode_write && go_sel == sel_zero) mux_ff <= 1'b1;
      if (issue && go_cmd == c_mode_write && go_sel == sel_one) bl_ff <= bl_fix;
      if (init_ff && step_ff == 3'h4 && state_ff == st_idle) begin
        init_ff      <= 1'b0;
        init_done_ff <= 1'b1;
      end
      if (init_req) begin
        init_ff      <= 1'b1;
        init_done_ff <= 1'b0;
        step_ff      <= 3'h0;
        mux_ff       <= 1'b0;
      end
    end
  end

  // ==================================================
  // pin drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_n_ff     <= 1'b1;
      we_n_ff     <= 1'b1;
      ref_n_ff    <= 1'b1;
      mb_n_ff     <= 1'b1;
      pin_addr_ff <= 21'h000000;
      pin_bank_ff <= 4'h0;
      cur_cmd_ff  <= c_read;
      cur_addr_ff <= 21'h000000;
      cur_mask_ff <= 16'h0000;
      cur_mux_ff  <= 1'b0;
    end else if (ce) begin
      cs_n_ff     <= ~issue;
      we_n_ff     <= ~issue | ~(go_cmd == c_write || go_cmd == c_mode_write);
      ref_n_ff    <= ~issue | ~(go_cmd == c_mode_write || go_cmd == c_refresh_bank || is_multi);
      mb_n_ff     <= ~issue | ~is_multi;
      pin_addr_ff <= 21'h000000;
      pin_bank_ff <= 4'h0;
      if (issue) begin
        cur_cmd_ff  <= go_cmd;
        cur_addr_ff <= go_addr;
        cur_mask_ff <= umask_ff;
        cur_mux_ff  <= mux_ff;
        // bank pins low on multibank refresh
        pin_bank_ff <= go_cmd == c_mode_write ? {2'h0, go_sel} : is_multi ? 4'h0 : ubank_ff;
        // bank mask on the address lanes
        pin_addr_ff <= is_multi ? (mux_ff ? mask_to_pins(umask_ff[7:0]) : {5'h00, umask_ff})
                               : (mux_ff ? first_half(go_addr) : go_addr);
      end else if (state_ff == st_fh && need_sh) begin
        pin_addr_ff <= cur_cmd_ff == c_refresh_multi ? mask_to_pins(cur_mask_ff[15:8])
                                                     : second_half(cur_addr_ff, wide36, bl_ff);
      end
    end
  end

  // ==================================================
  // multibank spacing and per-bank row cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mbd_ff     <= 8'h00;
      saw_ff     <= 8'h00;
      saw_num_ff <= 3'h0;
    end else if (ce) begin
      if (issue && is_multi) mbd_ff <= 8'(mb_min_delay_cyc - 1);
      else if (mbd_ff != 8'h00) mbd_ff <= mbd_ff - 8'h01;
      if (issue && is_multi && saw_ff == 8'h00) begin
        saw_ff     <= 8'(mb_window_cyc - 1);
        saw_num_ff <= 3'h1;
      end else begin
        if (saw_ff != 8'h00) saw_ff <= saw_ff - 8'h01;
        if (issue && is_multi) saw_num_ff <= saw_num_ff + 3'h1;
      end
    end
  end

  for (genvar b = 0; b < banks; b++) begin : g_bank
    wire hit = issue && (is_multi ? umask_ff[b] : (go_cmd != c_mode_write && ubank_ff == 4'(b)));
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) rc_cnt_ff[b] <= 8'h00;
      else if (ce) rc_cnt_ff[b] <= hit ? 8'(row_cycle_cyc - 1) :
                                   rc_cnt_ff[b] != 8'h00 ? rc_cnt_ff[b] - 8'h01 : 8'h00;
    end
    assign busy[b] = rc_cnt_ff[b] != 8'h00;
  end

  assign link.cs_n  = cs_n_ff;
  assign link.we_n  = we_n_ff;
  assign link.ref_n = ref_n_ff;
  assign link.mb_n  = mb_n_ff;
  assign link.addr  = pin_addr_ff;
  assign link.bank  = pin_bank_ff;
endmodule

// >>> tb/mux_link_checker.sv
// assertions on the command pins between the two ends
`timescale 1ns/1ps
module mux_link_checker
  import mux_addr_pkg::*;
#(
  parameter bit wide36 = 1'b0
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        cs_n,
  input wire logic        we_n,
  input wire logic        ref_n,
  input wire logic        mb_n,
  input wire logic [20:0] addr,
  input wire logic [3:0]  bank
);
  // ==========
  // helpers: split mode as seen on the pins, second-half cycle
  logic split_ff;
  logic half2_ff;
  // mask lanes may use pin A0 in the second half of a multibank refresh
  logic mref2_ff;
  wire  mode_w    = !cs_n && !we_n && !ref_n;
  wire  bref      = !cs_n && we_n && !ref_n && mb_n;
  wire  mref      = !cs_n && we_n && !ref_n && !mb_n;
  wire  nxt_split = (mode_w && bank == 4'h0) ? addr[mux_bit] : split_ff;
  // bank refresh has no second half, so the next edge is free
  wire  nxt_half2 = split_ff && !cs_n && !bref;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      split_ff <= 1'b0;
      half2_ff <= 1'b0;
      mref2_ff <= 1'b0;
    end else begin
      split_ff <= nxt_split;
      half2_ff <= nxt_half2;
      mref2_ff <= split_ff && mref;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet2;
    cs_n [*2];
  endsequence
  // ==========
  // assertions
  a_mode_bank: assert property (mode_w |-> bank[3:2] == 2'h0 && bank[1:0] != 2'h3)
    else $error("mode write bank pins bad");
  a_split_bit: assert property (mode_w && bank == 4'h0 |-> addr[mux_bit])
    else $error("mode zero split bit low");
  a_mode_wait: assert property (mode_w |=> cs_n [*8])
    else $error("command too soon after mode write");
  a_no_half2: assert property (half2_ff |-> cs_n)
    else $error("command on second half edge");
  a_multi_gap: assert property (split_ff && mref |=> s_quiet2)
    else $error("command too soon after multibank");
  a_half2_map: assert property (half2_ff |-> (addr & 21'h1998c6) == 21'h0 &&
    (mref2_ff ? (addr & 21'h064000) == 21'h0 : !addr[0]))
    else $error("second half on unused pins");
  a_half1_map: assert property (split_ff && !cs_n |-> (addr & 21'h1998c6) == 21'h0)
    else $error("first half on unused pins");
  a_wide_burst: assert property (mode_w && bank == 4'h1 && wide36 |-> addr[4:3] != burst_of_eight)
    else $error("burst of eight on wide part");
endmodule

// >>> tb/muxed_address_command_front_end_tb.sv
// self-checking bench: controller and device joined over the split-address link
`timescale 1ns/1ps
module muxed_address_command_front_end_tb;
  import mux_addr_pkg::*;
  typedef struct {cmd_t c; logic [20:0] a; logic [3:0] b; logic [15:0] m;} row_t;
  localparam logic [31:0] lat = 32'h2;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, rd_p, wr_p, ref_p, rc_s, rd_d, wr_d, mux_m, odt_on;
  logic [1:0]  odt_v;
  logic [20:0] op_a;
  logic [3:0]  op_b;
  logic [15:0] ref_b;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;
  wire  [5:0]  pv = {rc_s, ref_p, wr_d, rd_d, wr_p, rd_p};
  row_t        rows [5] = '{'{c_read, 21'h0abcde, 4'h3, 16'h0}, '{c_write, 21'h0f0f0f, 4'h9, 16'h0},
    '{c_refresh_bank, 21'h0, 4'h5, 16'h0}, '{c_refresh_multi, 21'h0, 4'h0, 16'ha5c3},
    '{c_read, 21'h0fffff, 4'hf, 16'h0}};
  mux_link_if link ();
  mux_addr_ctrl #(.wide36(1'b1)) mux_addr_ctrl_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata), .pready_ff(pready), .pslverr_ff(pslverr), .link(link.ctrl));
  mux_addr_device #(.wide36(1'b1)) mux_addr_device_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .link(link.dev), .rd_pulse_ff(rd_p), .wr_pulse_ff(wr_p), .ref_pulse_ff(ref_p),
    .rc_start_ff(rc_s), .rd_due_ff(rd_d), .wr_due_ff(wr_d), .mux_mode_ff(mux_m),
    .odt_on_ff(odt_on), .odt_value_ff(odt_v), .op_addr_ff(op_a), .op_bank_ff(op_b),
    .ref_banks_ff(ref_b));
  mux_link_checker #(.wide36(1'b1)) mux_link_checker_i (.pclk(pclk), .presetn(presetn),
    .cs_n(link.cs_n), .we_n(link.we_n), .ref_n(link.ref_n), .mb_n(link.mb_n),
    .addr(link.addr), .bank(link.bank));
  always #25 pclk = ~pclk;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // counts edges until the chosen pulse is seen, giving up after 40
  task automatic wait_bit(input int k, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pv[k] !== 1'b1 && n < 40);
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    int n;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset", 32'h1, {mux_m, odt_on, ref_b, link.cs_n});
    apb(1'b1, zero_off, lat);
    apb(1'b1, one_off, 32'h01);
    apb(1'b1, two_off, 32'h0);
    apb(1'b1, ctrl_off, 32'h2);
    do apb(1'b0, status_off, 32'h0); while (rd[0] !== 1'b1);
    chk("modes", 32'h7, {mux_m, odt_on, odt_v == 2'h1});
    $display("test init done");
    foreach (rows[i]) begin
      apb(1'b1, addr_off, {11'h0, rows[i].a});
      apb(1'b1, mask_off, {16'h0, rows[i].m});
      apb(1'b1, ctrl_off, {20'h0, rows[i].b, 1'b0, rows[i].c, 4'h1});
      wait_bit(5, n);
      wait_bit(rows[i].c < c_refresh_bank ? int'(rows[i].c) : 4, n);
      chk("pulse", 32'h1, 32'(n));
      if (rows[i].c < c_refresh_bank) begin
        wait_bit(int'(rows[i].c) + 2, n);
        chk("latency", lat + 32'h1, 32'(n));
        chk("addr", {11'h0, rows[i].a}, {11'h0, op_a});
        chk("bank", {28'h0, rows[i].b}, {28'h0, op_b});
      end else begin
        chk("banks", rows[i].c == c_refresh_bank ? 32'h1 << rows[i].b : {16'h0, rows[i].m},
          {16'h0, ref_b});
      end
      do apb(1'b0, status_off, 32'h0); while (rd[3] !== 1'b0 || rd[1] !== 1'b0);
      chk("split", 32'h1, {31'h0, rd[2]});
      $display("test row %0d done", i);
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    $display("test unmapped done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset again", 32'h1, {mux_m, odt_on, ref_b, link.cs_n});
    apb(1'b0, status_off, 32'h0);
    chk("status", 32'h0, rd);
    $display("test reset again done");
    wrap_up();
  end
endmodule
